// ==== rtl/lpm_pkg.sv ====
package lpm_pkg;

    // ------------------------------------------------------------
    // Bus addressing
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR   = 7'h13;
    localparam logic [7:0] REG_FIRST     = 8'h80;
    localparam logic [7:0] REG_LAST      = 8'h90;
    localparam int         REG_COUNT     = 17;

    // Register indices relative to REG_FIRST.
    localparam logic [4:0] IDX_COMMAND   = 5'h00;
    localparam logic [4:0] IDX_IDENT     = 5'h01;
    localparam logic [4:0] IDX_AMB_SETUP = 5'h04;
    localparam logic [4:0] IDX_AMB_HIGH  = 5'h05;
    localparam logic [4:0] IDX_AMB_LOW   = 5'h06;
    localparam logic [4:0] IDX_DIST_HIGH = 5'h07;
    localparam logic [4:0] IDX_DIST_LOW  = 5'h08;

    // Identity byte: the value is arbitrary.
    localparam logic [7:0] IDENT_VALUE   = 8'h5a;

    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int BIT_LOCK       = 7;
    localparam int BIT_AMB_READY  = 6;
    localparam int BIT_DIST_READY = 5;
    localparam int BIT_AMB_SINGLE = 4;
    localparam int BIT_DIST_SINGLE = 3;
    localparam int BIT_AMB_PERIOD = 2;
    localparam int BIT_DIST_PERIOD = 1;
    localparam int BIT_SELF_TIMED = 0;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Self-timed pacing, in clock cycles of mclk
    // ------------------------------------------------------------
    localparam int AMB_PERIOD_CYCLES  = 12500000;
    localparam int DIST_PERIOD_CYCLES = 12500000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b011,
        ST_WBYTE = 3'b010,
        ST_RBYTE = 3'b110,
        ST_RACK  = 3'b111,
        ST_WAIT  = 3'b101
    } lpm_state_type;

    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } lpm_result_type;

endpackage

// ==== rtl/lpm_tick_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Free-running pacing counter; emits one pulse per period while enabled.
module lpm_tick_timer #(
    parameter int PERIOD = 12500000
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Control
    input  wire logic enable,
    output logic      tick
);

    logic [31:0] count;
    wire         at_end = (count == 32'(PERIOD - 1));

    always_ff @(posedge mclk)
    begin
        if (!rst_b || !enable)
            count <= 32'h0;
        else if (at_end)
            count <= 32'h0;
        else
            count <= count + 32'h1;
    end

    assign tick = enable && at_end;

endmodule

`default_nettype wire

// ==== rtl/lpm_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// - seventeen byte registers, all reachable over bus
// - works at any bus speed slow enough for mclk sampling, no setup
// - answers only to target address 13h
// - registers mapped at 80h through 90h
// - ambient ready set on result, cleared reading 5/6
// - distance ready set on result, cleared reading 7/8
// - both single requests together start both conversions
// - distance periodic paced by self-timed timer
// - single requests ignored while self-timed enabled
// - interrupt pin is open drain, pulls low
module lpm_ctrl #(
    parameter int AMB_PERIOD  = lpm_pkg::AMB_PERIOD_CYCLES,
    parameter int DIST_PERIOD = lpm_pkg::DIST_PERIOD_CYCLES
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    // Serial bus pins
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    // Interrupt pin
    input  wire logic                   int_request,
    output logic                        int_out,
    output logic                        int_oe,
    // Converter front end
    output logic                        amb_start,
    output logic                        dist_start,
    output logic [7:0]                  amb_setup,
    input  wire lpm_pkg::lpm_result_type amb_result,
    input  wire lpm_pkg::lpm_result_type dist_result
);

    // ------------------------------------------------------------
    // Bus line edges
    // ------------------------------------------------------------
    // Edges are found purely from sampled levels, so any bus speed
    // slow enough for the sampling clock works without setup.
    logic scl_q;
    logic sda_q;
    wire  scl_rise = scl_in && !scl_q;
    wire  scl_fall = !scl_in && scl_q;
    wire  bus_start = scl_in && scl_q && sda_q && !sda_in;
    wire  bus_stop  = scl_in && scl_q && !sda_q && sda_in;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] regs [lpm_pkg::REG_COUNT];
    logic       amb_ready;
    logic       dist_ready;
    logic       amb_single;
    logic       dist_single;
    logic [2:0] mode_bits;
    logic [4:0] ptr;

    wire self_timed = mode_bits[lpm_pkg::BIT_SELF_TIMED];
    wire [7:0] command_byte = {1'b1, amb_ready, dist_ready,
                               amb_single, dist_single, mode_bits};
    wire [7:0] read_byte =
        (ptr == lpm_pkg::IDX_COMMAND) ? command_byte :
        (ptr == lpm_pkg::IDX_IDENT)   ? lpm_pkg::IDENT_VALUE :
        regs[ptr];

    // ------------------------------------------------------------
    // Target state machine
    // ------------------------------------------------------------
    lpm_pkg::lpm_state_type state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic       read_mode;
    logic       have_ptr;
    logic       drive_low;

    wire [7:0] next_shift = {shift[6:0], sda_in};
    wire addr_hit  = (shift[7:1] == lpm_pkg::TARGET_ADDR);
    wire ptr_valid = (shift >= lpm_pkg::REG_FIRST) &&
                     (shift <= lpm_pkg::REG_LAST);
    wire [4:0] ptr_index = 5'(shift - lpm_pkg::REG_FIRST);
    wire byte_done = scl_fall && (bit_cnt == 4'h8);
    wire load_read = (state == lpm_pkg::ST_ACK) && scl_fall && read_mode;
    wire reload_read = (state == lpm_pkg::ST_RACK) && scl_rise && !sda_in;
    wire data_write = (state == lpm_pkg::ST_WBYTE) && byte_done && have_ptr;

    always_ff @(posedge mclk)
    begin
        if (!rst_b || bus_stop)
        begin
            state     <= lpm_pkg::ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            read_mode <= 1'b0;
            have_ptr  <= 1'b0;
            drive_low <= 1'b0;
            ptr       <= rst_b ? ptr : 5'h00;
        end
        else if (bus_start)
        begin
            state     <= lpm_pkg::ST_ADDR;
            bit_cnt   <= 4'h0;
            have_ptr  <= 1'b0;
            drive_low <= 1'b0;
        end
        else
        begin
            if (scl_rise && bit_cnt != 4'h8)
            begin
                shift   <= next_shift;
                bit_cnt <= bit_cnt + 4'h1;
            end
            case (state)
                lpm_pkg::ST_ADDR:
                    if (byte_done)
                    begin
                        state     <= addr_hit ? lpm_pkg::ST_ACK
                                              : lpm_pkg::ST_WAIT;
                        drive_low <= addr_hit;
                        read_mode <= shift[0];
                        bit_cnt   <= 4'h0;
                    end
                lpm_pkg::ST_ACK:
                    if (scl_fall)
                    begin
                        bit_cnt <= 4'h0;
                        if (read_mode)
                        begin
                            state     <= lpm_pkg::ST_RBYTE;
                            shift     <= read_byte;
                            drive_low <= !read_byte[7];
                        end
                        else
                        begin
                            state     <= lpm_pkg::ST_WBYTE;
                            drive_low <= 1'b0;
                        end
                    end
                lpm_pkg::ST_WBYTE:
                    if (byte_done)
                    begin
                        bit_cnt <= 4'h0;
                        if (have_ptr || ptr_valid)
                        begin
                            state     <= lpm_pkg::ST_ACK;
                            drive_low <= 1'b1;
                        end
                        else
                            state <= lpm_pkg::ST_WAIT;
                        if (!have_ptr && ptr_valid)
                        begin
                            ptr      <= ptr_index;
                            have_ptr <= 1'b1;
                        end
                    end
                lpm_pkg::ST_RBYTE:
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'h8)
                        begin
                            state     <= lpm_pkg::ST_RACK;
                            drive_low <= 1'b0;
                        end
                        // The rising edge has already shifted the next bit
                        // to the top, so a second shift here would skip one.
                        else
                            drive_low <= !shift[7];
                    end
                lpm_pkg::ST_RACK:
                    if (scl_rise)
                        state <= sda_in ? lpm_pkg::ST_WAIT : lpm_pkg::ST_ACK;
                lpm_pkg::ST_IDLE,
                lpm_pkg::ST_WAIT:
                    drive_low <= 1'b0;
                default:
                    state <= lpm_pkg::ST_IDLE;
            endcase
        end
    end

    // Reading byte by byte re-reads the addressed register.
    wire read_taken = load_read || reload_read;
    wire rd_amb  = read_taken && (ptr == lpm_pkg::IDX_AMB_HIGH ||
                                  ptr == lpm_pkg::IDX_AMB_LOW);
    wire rd_dist = read_taken && (ptr == lpm_pkg::IDX_DIST_HIGH ||
                                  ptr == lpm_pkg::IDX_DIST_LOW);

    // ------------------------------------------------------------
    // Measurement control
    // ------------------------------------------------------------
    logic amb_busy;
    logic dist_busy;
    logic amb_tick;
    logic dist_tick;

    wire cmd_write = data_write && (ptr == lpm_pkg::IDX_COMMAND);
    wire amb_req  = cmd_write && !self_timed &&
                    shift[lpm_pkg::BIT_AMB_SINGLE];
    wire dist_req = cmd_write && !self_timed &&
                    shift[lpm_pkg::BIT_DIST_SINGLE];
    wire amb_go  = !amb_busy && (amb_req || amb_tick);
    wire dist_go = !dist_busy && (dist_req || dist_tick);

    lpm_tick_timer #(.PERIOD(AMB_PERIOD)) u_amb_timer (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .enable (self_timed && mode_bits[lpm_pkg::BIT_AMB_PERIOD]),
        .tick   (amb_tick)
    );

    lpm_tick_timer #(.PERIOD(DIST_PERIOD)) u_dist_timer (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .enable (self_timed && mode_bits[lpm_pkg::BIT_DIST_PERIOD]),
        .tick   (dist_tick)
    );

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            mode_bits   <= 3'h0;
            amb_single  <= 1'b0;
            dist_single <= 1'b0;
            amb_busy    <= 1'b0;
            dist_busy   <= 1'b0;
            amb_start   <= 1'b0;
            dist_start  <= 1'b0;
            amb_ready   <= 1'b0;
            dist_ready  <= 1'b0;
        end
        else
        begin
            if (cmd_write)
                mode_bits <= shift[2:0];
            amb_start  <= amb_go;
            dist_start <= dist_go;
            // A single request stays visible until its result lands.
            if (amb_result.done)
            begin
                amb_single <= 1'b0;
                amb_busy   <= 1'b0;
            end
            else if (amb_go)
                amb_busy <= 1'b1;
            if (amb_req)
                amb_single <= 1'b1;
            if (dist_result.done)
            begin
                dist_single <= 1'b0;
                dist_busy   <= 1'b0;
            end
            else if (dist_go)
                dist_busy <= 1'b1;
            if (dist_req)
                dist_single <= 1'b1;
            // Arrival beats a clearing read in the same cycle.
            amb_ready  <= amb_result.done  || (amb_ready && !rd_amb);
            dist_ready <= dist_result.done || (dist_ready && !rd_dist);
        end
    end

    // ------------------------------------------------------------
    // Byte storage and results
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < lpm_pkg::REG_COUNT; g++)
        begin : g_reg
            always_ff @(posedge mclk)
            begin
                if (!rst_b)
                    regs[g] <= lpm_pkg::RESET_BYTE;
                else if (g == lpm_pkg::IDX_AMB_HIGH && amb_result.done)
                    regs[g] <= amb_result.value[15:8];
                else if (g == lpm_pkg::IDX_AMB_LOW && amb_result.done)
                    regs[g] <= amb_result.value[7:0];
                else if (g == lpm_pkg::IDX_DIST_HIGH && dist_result.done)
                    regs[g] <= dist_result.value[15:8];
                else if (g == lpm_pkg::IDX_DIST_LOW && dist_result.done)
                    regs[g] <= dist_result.value[7:0];
                else if (data_write && ptr == 5'(g) &&
                         (g < 5 || g > 8))
                    regs[g] <= shift;
            end
        end
    endgenerate

    assign amb_setup = regs[lpm_pkg::IDX_AMB_SETUP];

    // ------------------------------------------------------------
    // Open-drain pins
    // ------------------------------------------------------------
    logic int_low;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            int_low <= 1'b0;
        else
            int_low <= int_request;
    end

    assign sda_out = 1'b0;
    assign sda_oe  = drive_low;
    assign int_out = 1'b0;
    assign int_oe  = int_low;

endmodule

`default_nettype wire

// ==== dv/lpm_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks of the measurement control block
// ----------------------------------------------------------------
module lpm_ctrl_props (
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_b,
    // Pins
    input wire logic                    scl_in,
    input wire logic                    sda_out,
    input wire logic                    sda_oe,
    input wire logic                    int_request,
    input wire logic                    int_out,
    input wire logic                    int_oe,
    // Converter side
    input wire logic                    amb_start,
    input wire logic                    dist_start,
    input wire logic [7:0]              amb_setup,
    input wire lpm_pkg::lpm_result_type amb_result,
    input wire lpm_pkg::lpm_result_type dist_result
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic amb_busy;
    logic dist_busy;

    // A start is owed its result before another may leave.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            amb_busy  <= 1'b0;
            dist_busy <= 1'b0;
        end
        else
        begin
            if (amb_start || amb_result.done)
                amb_busy <= amb_start;
            if (dist_start || dist_result.done)
                dist_busy <= dist_start;
        end
    end

    sequence oe_rise;
        $rose(sda_oe);
    endsequence

    // Host phases last at least three cycles, so a driven bit stands longer.
    sequence oe_stand;
        sda_oe [*4];
    endsequence

    sda_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    int_pin_a: assert property ($past(rst_b) |->
        !int_out && int_oe == $past(int_request))
        else $error("interrupt pin does not follow request");
    amb_pulse_a: assert property (amb_start |=> !amb_start)
        else $error("ambient start longer than one cycle");
    dist_pulse_a: assert property (dist_start |=> !dist_start)
        else $error("distance start longer than one cycle");
    amb_busy_a: assert property (amb_busy |-> !amb_start)
        else $error("ambient start while converting");
    dist_busy_a: assert property (dist_busy |-> !dist_start)
        else $error("distance start while converting");
    ack_stand_a: assert property (oe_rise |-> oe_stand)
        else $error("data drive too short");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    oe_hold_a: assert property (sda_oe && scl_in |=> sda_oe)
        else $error("data drive released while clock high");
    setup_scl_a: assert property ($changed(amb_setup) |-> !scl_in)
        else $error("setup register changed outside a write");
endmodule
`default_nettype wire

// ==== dv/lpm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bus controller model
// ----------------------------------------------------------------
module lpm_host_model (
    // Clock
    input  wire logic mclk,
    // Bus
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // Cycles per bus clock phase; tests vary it to cover bus speeds.
    int half = 4;

    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Data moves one cycle after the clock falls, never with it.
    task automatic xbit(input logic b, output logic r);
        tick(1);
        sda_pull = !b;
        tick(half - 1);
        scl = 1'b1;
        tick(half / 2);
        r = sda_line;
        tick(half - half / 2);
        scl = 1'b0;
    endtask

    task automatic start_c;
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop_c;
        tick(1);
        sda_pull = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(4);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(b[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask

    // The controller refuses the byte, which ends the read.
    task automatic recv(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(1'b1, b[i]);
        xbit(1'b1, r);
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic k1, k2, k3;
        start_c;
        send({lpm_pkg::TARGET_ADDR, 1'b0}, k1);
        send(a, k2);
        send(d, k3);
        stop_c;
        ok = k1 & k2 & k3;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        logic k1, k2, k3;
        start_c;
        send({lpm_pkg::TARGET_ADDR, 1'b0}, k1);
        send(a, k2);
        stop_c;
        start_c;
        send({lpm_pkg::TARGET_ADDR, 1'b1}, k3);
        recv(d);
        stop_c;
        ok = k1 & k2 & k3;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_light_proximity_measure_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_light_proximity_measure_control;
    localparam int PERIOD = 50;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
        logic       ack;
    } lpm_row_type;

    logic                    mclk;
    logic                    rst_b;
    logic                    scl;
    logic                    sda_pull;
    logic                    sda_line;
    logic                    int_request;
    logic                    sda_out;
    logic                    sda_oe;
    logic                    int_out;
    logic                    int_oe;
    logic                    amb_start;
    logic                    dist_start;
    logic [7:0]              amb_setup;
    lpm_pkg::lpm_result_type res [2];
    int                      errors;
    int                      compares;
    int                      cycles;
    int                      wait_cnt [2];
    int                      n_start [2];
    int                      n_both;
    logic [15:0]             res_val [2] = '{16'hbeef, 16'h1234};
    lpm_row_type             rows [6] = '{
        '{8'h81, 8'h33, lpm_pkg::IDENT_VALUE, 1'b1},
        '{8'h82, 8'ha5, 8'ha5, 1'b1},
        '{8'h84, 8'h3c, 8'h3c, 1'b1},
        '{8'h85, 8'hff, 8'h00, 1'b1},
        '{8'h90, 8'h7e, 8'h7e, 1'b1},
        '{8'h91, 8'h11, 8'h00, 1'b0}};

    // The pull-up wins unless someone pulls the line low.
    assign sda_line = !(sda_pull | (sda_oe & !sda_out));

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    lpm_ctrl #(.AMB_PERIOD(PERIOD), .DIST_PERIOD(PERIOD)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .int_request(int_request),
        .int_out(int_out), .int_oe(int_oe), .amb_start(amb_start),
        .dist_start(dist_start), .amb_setup(amb_setup),
        .amb_result(res[0]), .dist_result(res[1]));

    lpm_host_model host_u (.mclk(mclk), .sda_line(sda_line), .scl(scl),
                           .sda_pull(sda_pull));

    // Converter front end: each start yields one result six cycles on.
    always @(posedge mclk)
    begin
        #1;
        if (amb_start && dist_start)
            n_both++;
        for (int k = 0; k < 2; k++)
        begin
            res[k].done = (wait_cnt[k] == 1);
            res[k].value = res_val[k];
            if (wait_cnt[k] != 0)
                wait_cnt[k]--;
            if ((k == 0) ? amb_start : dist_start)
            begin
                wait_cnt[k] = 6;
                n_start[k]++;
            end
        end
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            $display("[FAIL] run time expected below limit");
            final_report;
        end
    end

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host_u.read_reg(a, d, ok);
        check($sformatf("read ack %h", a), 1'b1, ok);
        check($sformatf("reg %h", a), exp, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host_u.write_reg(a, d, ok);
        check($sformatf("write ack %h", a), 1'b1, ok);
    endtask

    task automatic counted(output int da, output int dd);
        int a0;
        int d0;
        a0 = n_start[0];
        d0 = n_start[1];
        host_u.tick(400);
        da = n_start[0] - a0;
        dd = n_start[1] - d0;
    endtask

    initial
    begin
        logic ok;
        int   da;
        int   dd;
        rst_b = 1'b0;
        int_request = 1'b0;
        res[0] = '0;
        res[1] = '0;
        host_u.tick(12);
        rst_b = 1'b1;
        host_u.tick(2);
        rd(8'h80, 8'h80);
        $display("test reset done");
        foreach (rows[i])
        begin
            host_u.write_reg(rows[i].addr, rows[i].data, ok);
            check("write ack", rows[i].ack, ok);
            if (rows[i].ack)
                rd(rows[i].addr, rows[i].exp);
        end
        check("amb setup", 8'h3c, amb_setup);
        host_u.start_c;
        host_u.send(8'h28, ok);
        host_u.stop_c;
        check("foreign address ack", 1'b0, ok);
        $display("test registers done");
        host_u.half = 3;
        wr(8'h90, 8'h81);
        rd(8'h90, 8'h81);
        host_u.half = 9;
        rd(8'h82, 8'ha5);
        host_u.half = 4;
        $display("test bus speed done");
        wr(8'h80, 8'h10);
        host_u.tick(20);
        check("amb starts", 16'd1, 16'(n_start[0]));
        check("dist starts", 16'd0, 16'(n_start[1]));
        rd(8'h80, 8'hc0);
        rd(8'h86, 8'hef);
        rd(8'h80, 8'h80);
        rd(8'h85, 8'hbe);
        $display("test ambient single done");
        res_val[0] = 16'hcafe;
        wr(8'h80, 8'h18);
        host_u.tick(20);
        check("both together", 16'd1, 16'(n_both));
        check("dist starts", 16'd1, 16'(n_start[1]));
        rd(8'h80, 8'he0);
        rd(8'h87, 8'h12);
        rd(8'h80, 8'hc0);
        rd(8'h85, 8'hca);
        rd(8'h80, 8'h80);
        rd(8'h88, 8'h34);
        $display("test both single done");
        wr(8'h80, 8'h01);
        wr(8'h80, 8'h19);
        counted(da, dd);
        check("starts while self-timed", 16'd0, 16'(da + dd));
        check("starts so far", 16'd3, 16'(n_start[0] + n_start[1]));
        rd(8'h80, 8'h81);
        wr(8'h80, 8'h05);
        counted(da, dd);
        check("amb periodic", 1'b1, da >= 7 && da <= 9);
        check("dist idle", 16'd0, 16'(dd));
        wr(8'h80, 8'h03);
        counted(da, dd);
        check("dist periodic", 1'b1, dd >= 7 && dd <= 9);
        check("amb idle", 16'd0, 16'(da));
        wr(8'h80, 8'h04);
        counted(da, dd);
        check("no pacing", 16'd0, 16'(da + dd));
        $display("test self-timed done");
        int_request = 1'b1;
        host_u.tick(2);
        check("int pin low", 2'b10, {int_oe, int_out});
        int_request = 1'b0;
        host_u.tick(2);
        check("int pin free", 2'b00, {int_oe, int_out});
        rst_b = 1'b0;
        host_u.tick(3);
        rst_b = 1'b1;
        host_u.tick(2);
        rd(8'h80, 8'h80);
        rd(8'h84, 8'h00);
        $display("test interrupt and reset done");
        final_report;
    end
endmodule

bind lpm_ctrl lpm_ctrl_props chk_u (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_request(int_request), .int_out(int_out),
    .int_oe(int_oe), .amb_start(amb_start), .dist_start(dist_start),
    .amb_setup(amb_setup), .amb_result(amb_result),
    .dist_result(dist_result));
`default_nettype wire
